/* inc/fifo_defs.svh */
// Constants for the nine-bit clocked FIFO with programmable flags.
`ifndef FIFO_DEFS_SVH
`define FIFO_DEFS_SVH
`define FIFO_DW 9
`define FIFO_AW 6
`define FIFO_PW 7
`define FIFO_OW 8
`define FIFO_DEPTH 7'h40
`define FIFO_DEPTH_WIDE 17'h00040
`define FIFO_OFS_EMPTY_LOW 2'h0
`define FIFO_OFS_EMPTY_HIGH 2'h1
`define FIFO_OFS_FULL_LOW 2'h2
`define FIFO_OFS_FULL_HIGH 2'h3
`define FIFO_OFS_LOW_DEFAULT 8'h07
`define FIFO_OFS_HIGH_DEFAULT 8'h00
`endif

/* inc/fifo_pkg.sv */
// Types for the nine-bit clocked FIFO.
`include "fifo_defs.svh"
package fifo_pkg;
   typedef enum logic {MODE_PROG_FLAGS, MODE_DUAL_WRITE} mode_type;
   typedef struct packed {
      logic [1:0] wclk_s;
      logic [1:0] rclk_s;
      logic [1:0] rst_s;
      logic [1:0] write_enable_primary_n_s;
      logic [1:0] wen2_s;
      logic [1:0] read_enable_a_n_s;
      logic [1:0] read_enable_b_n_s;
      logic [1:0] oe_s;
      logic [1:0][`FIFO_DW-1:0] din_s;
      logic wclk_d;
      logic rclk_d;
      mode_type mode;
      logic [`FIFO_PW-1:0] wptr;
      logic [`FIFO_PW-1:0] rptr;
      logic [`FIFO_PW-1:0] wgray;
      logic [`FIFO_PW-1:0] rgray;
      logic [1:0][`FIFO_PW-1:0] rgray_w;
      logic [1:0][`FIFO_PW-1:0] wgray_r;
      logic [(1 << `FIFO_AW)-1:0][`FIFO_DW-1:0] mem;
      logic [`FIFO_DW-1:0] dout;
      logic dout_oe;
      logic full_n;
      logic afull_n;
      logic empty_n;
      logic aempty_n;
      logic [3:0][`FIFO_OW-1:0] offs;
      logic [1:0] ld_wsel;
      logic [1:0] ld_rsel;
   } fifo_state_type;
endpackage

/* rtl/sync_fifo9.sv */
// Nine-bit FIFO with sampled write and read clocks, flags and offset registers.
`timescale 1ns/1ps
`include "fifo_defs.svh"

// Behaviour
// RULE1 - Pin reset returns write and read pointers to the first location.
// RULE2 - After reset full and almost-full read high, empty and almost-empty low.
// RULE3 - Reset clears the output register and restores default flag offsets.
// RULE4 - Flag mode: primary enable low at write edge stores next word.
// RULE5 - Flag mode: primary enable high writes nothing.
// RULE6 - Full flag goes low and every write enable is ignored; flag-mode offset loads still go through while full.
// RULE7 - Full releases after a read; full flags change only at write edges.
// RULE8 - Both read enables low and not empty moves next word out.
// RULE9 - Either read enable high holds output and read pointer.
// RULE10 - Pointers equal means empty flag low and reads ignored.
// RULE11 - Empty releases after a write; empty flags change only at read edges.
// RULE12 - Output bus driven while output enable low, released while high.
// RULE13 - Second enable pin level during reset picks dual-write or flag mode.
// RULE14 - Dual-write mode writes only with primary low and second enable high.
// RULE15 - Flag mode has four eight-bit offset registers, loaded and read back.
// RULE16 - Load and primary enable low write offsets in fixed wrapping order.
// RULE17 - Offset sequence position is kept when load is raised between loads.
// RULE18 - Load low and reads enabled present offsets in the same order.
// RULE19 - Outside logic never writes and reads offsets in the same period.
// RULE20 - Full flag asserts when stored count equals the depth of 64.
// RULE21 - Almost-full low at depth minus full offset, default seven.
// RULE22 - Almost-empty low at n or fewer words, high above, default seven.
// RULE23 - After reset the output bus shows zeros while enabled.
// RULE24 - Pointers cross between sides Gray coded through two flops.
module sync_fifo9 (
   // System clock and reset.
   input wire logic ref_clk,
   input wire logic rstn,
   // Write port pins.
   input wire logic write_clock,
   input wire logic active_low_reset,
   input wire logic write_enable_primary_n,
   input wire logic write_enable2_or_load,
   input wire logic [`FIFO_DW-1:0] data_in,
   // Read port pins.
   input wire logic read_clock,
   input wire logic read_enable_a_n,
   input wire logic read_enable_b_n,
   input wire logic output_enable_n,
   output logic [`FIFO_DW-1:0] data_out,
   output logic data_out_oe,
   // Status flags.
   output logic full_flag_n,
   output logic almost_full_flag_n,
   output logic empty_flag_n,
   output logic almost_empty_flag_n
);

   fifo_pkg::fifo_state_type s_reg;
   fifo_pkg::fifo_state_type s_next;
   logic wr_edge;
   logic rd_edge;
   logic pin_reset;
   logic wr_full;
   logic rd_empty;
   logic wr_go;
   logic rd_go;
   logic ld_write;
   logic ld_read;
   logic [`FIFO_PW-1:0] wcount;
   logic [`FIFO_PW-1:0] rcount;
   logic [`FIFO_DW-1:0] mem_head;

   function automatic logic [`FIFO_PW-1:0] gray_to_bin(input logic [`FIFO_PW-1:0] g);
      logic [`FIFO_PW-1:0] b;
      b[`FIFO_PW-1] = g[`FIFO_PW-1];
      for (int i = `FIFO_PW - 2; i >= 0; i--) begin
         b[i] = b[i + 1] ^ g[i];
      end
      return b;
   endfunction

   function automatic logic [`FIFO_PW-1:0] bin_to_gray(input logic [`FIFO_PW-1:0] b);
      return b ^ (b >> 1);
   endfunction

   // Edges are found on the second sync stage; the first is never looked at.
   assign wr_edge = s_reg.wclk_s[1] & ~s_reg.wclk_d;
   assign rd_edge = s_reg.rclk_s[1] & ~s_reg.rclk_d;
   assign pin_reset = ~s_reg.rst_s[1];
   // Counts use only the synchronised Gray copy of the far pointer.
   assign wcount = `FIFO_PW'(s_reg.wptr - gray_to_bin(s_reg.rgray_w[1])); // RULE24
   assign rcount = `FIFO_PW'(gray_to_bin(s_reg.wgray_r[1]) - s_reg.rptr); // RULE24
   assign wr_full = (wcount == `FIFO_DEPTH); // RULE20
   assign rd_empty = (s_reg.rptr == gray_to_bin(s_reg.wgray_r[1])); // RULE10
   assign ld_write = (s_reg.mode == fifo_pkg::MODE_PROG_FLAGS) & ~s_reg.wen2_s[1] &
      ~s_reg.write_enable_primary_n_s[1]; // RULE16
   assign ld_read = (s_reg.mode == fifo_pkg::MODE_PROG_FLAGS) & ~s_reg.wen2_s[1] &
      ~s_reg.read_enable_a_n_s[1] & ~s_reg.read_enable_b_n_s[1]; // RULE18
   // In flag mode the second pin is the load strobe, so a data write also wants it high.
   // Keeping both branches apart leaves room for a mode that gates writes differently.
   always_comb begin
      if (s_reg.mode == fifo_pkg::MODE_DUAL_WRITE) begin
         wr_go = ~s_reg.write_enable_primary_n_s[1] & s_reg.wen2_s[1] & ~wr_full; // RULE14 RULE6
      end else begin
         wr_go = ~s_reg.write_enable_primary_n_s[1] & s_reg.wen2_s[1] & ~wr_full; // RULE4 RULE5 RULE6
      end
   end
   assign rd_go = ~s_reg.read_enable_a_n_s[1] & ~s_reg.read_enable_b_n_s[1] & ~rd_empty & ~ld_read; // RULE8 RULE9
   assign mem_head = s_reg.mem[s_reg.rptr[`FIFO_AW-1:0]];

   always_comb begin
      logic [`FIFO_PW-1:0] wp_new;
      logic [`FIFO_PW-1:0] rp_new;
      logic [`FIFO_PW-1:0] wc_new;
      logic [`FIFO_PW-1:0] rc_new;
      wp_new = s_reg.wptr;
      rp_new = s_reg.rptr;
      wc_new = wcount;
      rc_new = rcount;
      s_next = s_reg;
      s_next.wclk_s = {s_reg.wclk_s[0], write_clock};
      s_next.rclk_s = {s_reg.rclk_s[0], read_clock};
      s_next.rst_s = {s_reg.rst_s[0], active_low_reset};
      s_next.write_enable_primary_n_s = {s_reg.write_enable_primary_n_s[0], write_enable_primary_n};
      s_next.wen2_s = {s_reg.wen2_s[0], write_enable2_or_load};
      s_next.read_enable_a_n_s = {s_reg.read_enable_a_n_s[0], read_enable_a_n};
      s_next.read_enable_b_n_s = {s_reg.read_enable_b_n_s[0], read_enable_b_n};
      s_next.oe_s = {s_reg.oe_s[0], output_enable_n};
      s_next.din_s = {s_reg.din_s[0], data_in};
      s_next.wclk_d = s_reg.wclk_s[1];
      s_next.rclk_d = s_reg.rclk_s[1];
      s_next.rgray_w = {s_reg.rgray_w[0], s_reg.rgray}; // RULE24
      s_next.wgray_r = {s_reg.wgray_r[0], s_reg.wgray}; // RULE24
      s_next.dout_oe = ~s_reg.oe_s[1]; // RULE12
      if (pin_reset) begin
         // The strap is caught while the pin reset is held, not by rstn.
         s_next.mode = s_reg.wen2_s[1] ? fifo_pkg::MODE_DUAL_WRITE :
            fifo_pkg::MODE_PROG_FLAGS; // RULE13
         s_next.wptr = '0; // RULE1
         s_next.rptr = '0; // RULE1
         s_next.wgray = '0;
         s_next.rgray = '0;
         s_next.rgray_w = '0;
         s_next.wgray_r = '0;
         s_next.dout = '0; // RULE3 RULE23
         s_next.full_n = 1'b1; // RULE2
         s_next.afull_n = 1'b1; // RULE2
         s_next.empty_n = 1'b0; // RULE2
         s_next.aempty_n = 1'b0; // RULE2
         s_next.offs[`FIFO_OFS_EMPTY_LOW] = `FIFO_OFS_LOW_DEFAULT; // RULE3
         s_next.offs[`FIFO_OFS_EMPTY_HIGH] = `FIFO_OFS_HIGH_DEFAULT; // RULE3
         s_next.offs[`FIFO_OFS_FULL_LOW] = `FIFO_OFS_LOW_DEFAULT; // RULE3
         s_next.offs[`FIFO_OFS_FULL_HIGH] = `FIFO_OFS_HIGH_DEFAULT; // RULE3
         s_next.ld_wsel = 2'h0;
         s_next.ld_rsel = 2'h0;
      end else begin
         if (wr_edge) begin
            if (ld_write) begin
               // Offset bytes are loaded one per edge; the index survives pauses.
               s_next.offs[s_reg.ld_wsel] = s_reg.din_s[1][`FIFO_OW-1:0]; // RULE15 RULE16
               s_next.ld_wsel = 2'(s_reg.ld_wsel + 2'h1); // RULE16 RULE17
            end else if (wr_go) begin
               s_next.mem[s_reg.wptr[`FIFO_AW-1:0]] = s_reg.din_s[1]; // RULE4 RULE14
               wp_new = `FIFO_PW'(s_reg.wptr + `FIFO_PW'(1));
               wc_new = `FIFO_PW'(wcount + `FIFO_PW'(1));
            end
            s_next.wptr = wp_new;
            s_next.wgray = bin_to_gray(wp_new); // RULE24
            // Write-side flags move only here, so a read is seen at a later edge.
            s_next.full_n = ~(wc_new == `FIFO_DEPTH); // RULE6 RULE7 RULE20
            s_next.afull_n = ~((17'(wc_new) + 17'({s_reg.offs[`FIFO_OFS_FULL_HIGH],
               s_reg.offs[`FIFO_OFS_FULL_LOW]})) >= `FIFO_DEPTH_WIDE); // RULE21 RULE7
         end
         if (rd_edge) begin
            if (ld_read) begin
               s_next.dout = {1'b0, s_reg.offs[s_reg.ld_rsel]}; // RULE15 RULE18
               s_next.ld_rsel = 2'(s_reg.ld_rsel + 2'h1); // RULE18
            end else if (rd_go) begin
               s_next.dout = mem_head; // RULE8
               rp_new = `FIFO_PW'(s_reg.rptr + `FIFO_PW'(1));
               rc_new = `FIFO_PW'(rcount - `FIFO_PW'(1));
            end
            s_next.rptr = rp_new;
            s_next.rgray = bin_to_gray(rp_new); // RULE24
            s_next.empty_n = (rc_new != '0); // RULE10 RULE11
            s_next.aempty_n = (16'(rc_new) > {s_reg.offs[`FIFO_OFS_EMPTY_HIGH],
               s_reg.offs[`FIFO_OFS_EMPTY_LOW]}); // RULE22 RULE11
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s_reg <= '0;
         s_reg.full_n <= 1'b1;
         s_reg.afull_n <= 1'b1;
         s_reg.rst_s <= 2'h0;
         s_reg.offs[`FIFO_OFS_EMPTY_LOW] <= `FIFO_OFS_LOW_DEFAULT;
         s_reg.offs[`FIFO_OFS_FULL_LOW] <= `FIFO_OFS_LOW_DEFAULT;
      end else begin
         s_reg <= s_next;
      end
   end

   assign data_out = s_reg.dout;
   assign data_out_oe = s_reg.dout_oe; // RULE12
   assign full_flag_n = s_reg.full_n;
   assign almost_full_flag_n = s_reg.afull_n;
   assign empty_flag_n = s_reg.empty_n;
   assign almost_empty_flag_n = s_reg.aempty_n;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);

   a_reset_pointers: assert property ( // RULE1
      pin_reset |=> s_reg.wptr == '0 && s_reg.rptr == '0)
      else $error("pointers not cleared by pin reset");
   a_reset_flag_levels: assert property ( // RULE2
      pin_reset |=> full_flag_n && almost_full_flag_n &&
      !empty_flag_n && !almost_empty_flag_n)
      else $error("flags wrong after pin reset");
   a_reset_out_offs: assert property ( // RULE3
      pin_reset |=> data_out == '0 &&
      s_reg.offs[`FIFO_OFS_FULL_LOW] == `FIFO_OFS_LOW_DEFAULT)
      else $error("output or offsets not restored");
   a_reset_zero_out: assert property ( // RULE23
      pin_reset |=> data_out == '0)
      else $error("output not zero after pin reset");

   a_write_advances: assert property ( // RULE4
      !pin_reset && wr_edge && !ld_write && wr_go |=>
      s_reg.wptr == `FIFO_PW'($past(s_reg.wptr) + `FIFO_PW'(1)))
      else $error("accepted write did not advance");
   a_flag_store: assert property ( // RULE4
      !pin_reset && wr_edge && s_reg.mode == fifo_pkg::MODE_PROG_FLAGS && !s_reg.write_enable_primary_n_s[1] &&
      s_reg.wen2_s[1] && !wr_full |=> s_reg.wptr == `FIFO_PW'($past(s_reg.wptr) + `FIFO_PW'(1)))
      else $error("flag mode write not stored");
   a_hold_no_store: assert property ( // RULE5
      !pin_reset && wr_edge && s_reg.mode == fifo_pkg::MODE_PROG_FLAGS && s_reg.write_enable_primary_n_s[1] |=>
      $stable(s_reg.mem) && $stable(s_reg.wptr))
      else $error("write taken with primary enable high");
   a_write_blocked: assert property ( // RULE6
      !pin_reset && wr_edge && (wr_full || s_reg.write_enable_primary_n_s[1]) |=>
      $stable(s_reg.wptr))
      else $error("write taken while full or disabled");
   a_full_no_store: assert property ( // RULE6
      !pin_reset && wr_edge && wr_full |=> $stable(s_reg.mem))
      else $error("memory changed while full");

   a_dual_gate: assert property ( // RULE14
      !pin_reset && wr_edge && s_reg.mode == fifo_pkg::MODE_DUAL_WRITE && !s_reg.wen2_s[1] |=>
      $stable(s_reg.wptr))
      else $error("dual mode wrote with second enable low");
   a_dual_store: assert property ( // RULE14
      !pin_reset && wr_edge && s_reg.mode == fifo_pkg::MODE_DUAL_WRITE && !s_reg.write_enable_primary_n_s[1] &&
      s_reg.wen2_s[1] && !wr_full |=> s_reg.wptr == `FIFO_PW'($past(s_reg.wptr) + `FIFO_PW'(1)))
      else $error("dual mode write not stored");
   a_strap_dual: assert property ( // RULE13
      pin_reset && s_reg.wen2_s[1] |=> s_reg.mode == fifo_pkg::MODE_DUAL_WRITE)
      else $error("strap high did not pick dual write");
   a_strap_flags: assert property ( // RULE13
      pin_reset && !s_reg.wen2_s[1] |=> s_reg.mode == fifo_pkg::MODE_PROG_FLAGS)
      else $error("strap low did not pick flag mode");

   a_full_write_edge: assert property ( // RULE7
      !wr_edge && !pin_reset |=> $stable(full_flag_n) &&
      $stable(almost_full_flag_n))
      else $error("write flags moved off a write edge");
   a_full_release: assert property ( // RULE7
      !pin_reset && wr_edge && wcount < 7'h3F |=> full_flag_n)
      else $error("full flag held with room left");
   a_empty_read_edge: assert property ( // RULE11
      !rd_edge && !pin_reset |=> $stable(empty_flag_n) &&
      $stable(almost_empty_flag_n))
      else $error("read flags moved off a read edge");
   a_empty_release: assert property ( // RULE11
      !pin_reset && rd_edge && rcount > 7'h01 |=> empty_flag_n)
      else $error("empty flag held with words stored");

   a_read_data: assert property ( // RULE8
      !pin_reset && rd_edge && rd_go |=>
      data_out == $past(mem_head) && s_reg.rptr != $past(s_reg.rptr))
      else $error("read did not deliver head word");
   a_read_ptr_step: assert property ( // RULE8
      !pin_reset && rd_edge && rd_go |=>
      s_reg.rptr == `FIFO_PW'($past(s_reg.rptr) + `FIFO_PW'(1)))
      else $error("read pointer did not step by one");
   a_read_hold: assert property ( // RULE9
      !pin_reset && rd_edge && (s_reg.read_enable_a_n_s[1] || s_reg.read_enable_b_n_s[1]) |=>
      $stable(data_out) && $stable(s_reg.rptr))
      else $error("output moved with read disabled");
   a_out_no_edge: assert property ( // RULE9
      !pin_reset && !rd_edge |=> $stable(data_out))
      else $error("output moved off a read edge");
   a_empty_ignores: assert property ( // RULE10
      !pin_reset && rd_edge && rd_empty |=> $stable(s_reg.rptr))
      else $error("read taken while empty");

   a_oe_follow: assert property ( // RULE12
      s_reg.oe_s[1] |=> !data_out_oe)
      else $error("bus driven while output disabled");
   a_oe_drive: assert property ( // RULE12
      !s_reg.oe_s[1] |=> data_out_oe)
      else $error("bus released while output enabled");

   a_offset_store: assert property ( // RULE15
      !pin_reset && wr_edge && ld_write |=>
      s_reg.offs[$past(s_reg.ld_wsel)] == $past(s_reg.din_s[1][`FIFO_OW-1:0]))
      else $error("offset byte not stored");
   a_load_order: assert property ( // RULE16
      !pin_reset && wr_edge && ld_write |=>
      s_reg.ld_wsel == 2'($past(s_reg.ld_wsel) + 2'h1))
      else $error("offset load sequence broken");
   a_load_keep: assert property ( // RULE17
      !pin_reset && !(wr_edge && ld_write) |=>
      $stable(s_reg.ld_wsel))
      else $error("offset position lost");
   a_offset_show: assert property ( // RULE18
      !pin_reset && rd_edge && ld_read |=>
      data_out == {1'b0, $past(s_reg.offs[s_reg.ld_rsel])})
      else $error("offset byte not shown");
   a_offset_read_step: assert property ( // RULE18
      !pin_reset && rd_edge && ld_read |=>
      s_reg.ld_rsel == 2'($past(s_reg.ld_rsel) + 2'h1))
      else $error("offset read sequence broken");

   a_full_at_depth: assert property ( // RULE20
      !pin_reset && wr_edge && wr_go && !ld_write && wcount == 7'h3F |=> !full_flag_n)
      else $error("full flag missing at depth");
   a_full_afull: assert property ( // RULE21
      !full_flag_n |-> !almost_full_flag_n)
      else $error("full without almost full");
   a_empty_aempty: assert property ( // RULE22
      !empty_flag_n |-> !almost_empty_flag_n)
      else $error("empty without almost empty");
   // Gray copies may only move one bit per edge, or the far side could read a torn value.
   a_wgray_step: assert property ( // RULE24
      !pin_reset |=> $onehot0(s_reg.wgray ^ $past(s_reg.wgray)))
      else $error("write pointer code moved more than one bit");
   a_rgray_step: assert property ( // RULE24
      !pin_reset |=> $onehot0(s_reg.rgray ^ $past(s_reg.rgray)))
      else $error("read pointer code moved more than one bit");

   c_fill_full: cover property (!full_flag_n);
   c_read_out: cover property (rd_edge && rd_go);
   c_offset_load: cover property (wr_edge && ld_write);
   c_offset_read: cover property (rd_edge && ld_read);
   c_dual_write: cover property (wr_edge && wr_go && s_reg.mode == fifo_pkg::MODE_DUAL_WRITE);

endmodule // sync_fifo9

/* bench/fifo_host_model.sv */
// Producer and consumer pin model for the nine-bit FIFO.
`timescale 1ns/1ps
module fifo_host_model (
   // System clock.
   input wire logic ref_clk,
   // Write side pins.
   output logic write_clock,
   output logic write_enable_primary_n,
   output logic write_enable2_or_load,
   output logic [8:0] data_in,
   // Read side pins.
   output logic read_clock,
   output logic read_enable_a_n,
   output logic read_enable_b_n
);
   initial begin
      write_clock = 1'b0;
      read_clock = 1'b0;
      write_enable_primary_n = 1'b1;
      write_enable2_or_load = 1'b0;
      data_in = 9'h000;
      read_enable_a_n = 1'b1;
      read_enable_b_n = 1'b1;
   end
   task automatic set_ld(input logic v);
      @(posedge ref_clk);
      write_enable2_or_load <= v;
   endtask
   // One 80 ns clock period per call; the pin clock stays low between calls.
   task automatic wr(input logic [8:0] d, input logic wen_n, input logic ld);
      @(posedge ref_clk);
      data_in <= d;
      write_enable_primary_n <= wen_n;
      write_enable2_or_load <= ld;
      repeat (3) @(posedge ref_clk);
      write_clock <= 1'b1;
      repeat (4) @(posedge ref_clk);
      write_clock <= 1'b0;
      // Hold time is over, so stale data must not look valid.
      data_in <= ~d;
      write_enable_primary_n <= 1'b1;
   endtask
   // Reads never overlap writes, so offsets are never written and read together.
   task automatic rd(input logic ra_n, input logic rb_n, input logic ld);
      @(posedge ref_clk);
      read_enable_a_n <= ra_n;
      read_enable_b_n <= rb_n;
      write_enable2_or_load <= ld;
      repeat (3) @(posedge ref_clk);
      read_clock <= 1'b1;
      repeat (4) @(posedge ref_clk);
      read_clock <= 1'b0;
      read_enable_a_n <= 1'b1;
   endtask
endmodule // fifo_host_model

/* bench/sync_fifo9_bench.sv */
// Self-checking bench for the nine-bit FIFO.
`timescale 1ns/1ps
`include "fifo_defs.svh"
module sync_fifo9_bench;
   logic ref_clk = 1'b0;
   logic rstn, active_low_reset, output_enable_n;
   logic write_clock, write_enable_primary_n, write_enable2_or_load;
   logic read_clock, read_enable_a_n, read_enable_b_n, data_out_oe;
   logic full_flag_n, almost_full_flag_n, empty_flag_n, almost_empty_flag_n;
   logic [8:0] data_in, data_out;
   logic [3:0] flags;
   int fails = 0;
   int cmp_count = 0;
   localparam logic [8:0] OFS_EXP [4] = '{9'h003, 9'h000, 9'h005, 9'h000};
   assign flags = {full_flag_n, almost_full_flag_n, empty_flag_n, almost_empty_flag_n};
   always #5 ref_clk = ~ref_clk;
   sync_fifo9 sync_fifo9_i (.ref_clk(ref_clk), .rstn(rstn), .write_clock(write_clock),
      .active_low_reset(active_low_reset), .write_enable_primary_n(write_enable_primary_n),
      .write_enable2_or_load(write_enable2_or_load), .data_in(data_in),
      .read_clock(read_clock), .read_enable_a_n(read_enable_a_n),
      .read_enable_b_n(read_enable_b_n), .output_enable_n(output_enable_n),
      .data_out(data_out), .data_out_oe(data_out_oe), .full_flag_n(full_flag_n),
      .almost_full_flag_n(almost_full_flag_n), .empty_flag_n(empty_flag_n),
      .almost_empty_flag_n(almost_empty_flag_n));
   fifo_host_model fifo_host_model_i (.ref_clk(ref_clk), .write_clock(write_clock),
      .write_enable_primary_n(write_enable_primary_n),
      .write_enable2_or_load(write_enable2_or_load), .data_in(data_in),
      .read_clock(read_clock), .read_enable_a_n(read_enable_a_n),
      .read_enable_b_n(read_enable_b_n));
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic pin_reset(input logic strap);
      fifo_host_model_i.set_ld(strap);
      active_low_reset <= 1'b0;
      repeat (8) @(posedge ref_clk);
      active_low_reset <= 1'b1;
      repeat (6) @(posedge ref_clk);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      rstn = 1'b0;
      active_low_reset = 1'b0;
      output_enable_n = 1'b0;
      repeat (12) @(posedge ref_clk);
      rstn <= 1'b1;
      pin_reset(1'b0);
      chk({5'h00, flags}, 9'h00C);
      chk(data_out, 9'h000);
      for (int i = 0; i < 4; i++) begin
         fifo_host_model_i.rd(1'b0, 1'b0, 1'b0);
         chk(data_out, {1'b0, i[0] ? `FIFO_OFS_HIGH_DEFAULT : `FIFO_OFS_LOW_DEFAULT});
      end
      fifo_host_model_i.wr(9'h103, 1'b0, 1'b0);
      fifo_host_model_i.wr(9'h000, 1'b1, 1'b1);
      fifo_host_model_i.wr(9'h000, 1'b0, 1'b0);
      fifo_host_model_i.wr(9'h105, 1'b0, 1'b0);
      fifo_host_model_i.wr(9'h000, 1'b0, 1'b0);
      for (int i = 0; i < 4; i++) begin
         fifo_host_model_i.rd(1'b0, 1'b0, 1'b0);
         chk(data_out, OFS_EXP[i]);
      end
      fifo_host_model_i.wr(9'h1AA, 1'b1, 1'b1);
      for (int i = 1; i <= 64; i++) begin
         fifo_host_model_i.wr(9'(i - 1), 1'b0, 1'b1);
         chk({5'h00, flags}, {5'h00, i != 64, i < 59, 2'b00});
      end
      fifo_host_model_i.wr(9'h1FF, 1'b0, 1'b1);
      fifo_host_model_i.rd(1'b1, 1'b0, 1'b1);
      chk({5'h00, flags}, 9'h003);
      fifo_host_model_i.rd(1'b0, 1'b0, 1'b1);
      chk(data_out, 9'h000);
      chk({5'h00, flags}, 9'h003);
      fifo_host_model_i.rd(1'b0, 1'b1, 1'b1);
      chk(data_out, 9'h000);
      fifo_host_model_i.wr(9'h000, 1'b1, 1'b1);
      chk({5'h00, flags}, 9'h00B);
      for (int i = 1; i < 64; i++) begin
         fifo_host_model_i.rd(1'b0, 1'b0, 1'b1);
         chk(data_out, 9'(i));
         chk({5'h00, flags}, {5'h00, 2'b10, i != 63, (63 - i) > 3});
      end
      fifo_host_model_i.rd(1'b0, 1'b0, 1'b1);
      chk(data_out, 9'h03F);
      output_enable_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk({8'h00, data_out_oe}, 9'h000);
      output_enable_n <= 1'b0;
      pin_reset(1'b1);
      chk({5'h00, flags}, 9'h00C);
      fifo_host_model_i.wr(9'h0AA, 1'b0, 1'b0);
      fifo_host_model_i.wr(9'h155, 1'b0, 1'b1);
      fifo_host_model_i.rd(1'b1, 1'b1, 1'b1);
      chk({5'h00, flags}, 9'h00E);
      fifo_host_model_i.rd(1'b0, 1'b0, 1'b1);
      chk(data_out, 9'h155);
      chk({8'h00, data_out_oe}, 9'h001);
      chk({5'h00, flags}, 9'h00C);
      tally_and_finish();
   end
endmodule // sync_fifo9_bench
